// ### rtl/crypto_dma_pkg.sv
// Package with register map, field layout and carrier types of the crypto DMA control block
package crypto_dma_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CRC = 8'h71;
  localparam logic [7:0] IDX_COUNTS = 8'h72;
  localparam logic [7:0] IDX_IV_LO = 8'h73;
  localparam logic [7:0] IDX_IV_HI = 8'h74;
  localparam logic [7:0] IDX_TRIPLE = 8'h75;
  localparam logic [7:0] IDX_BLOCK = 8'h76;
  localparam logic [7:0] IDX_RKFIFO = 8'h77;
  localparam logic [7:0] IDX_THREAD = 8'h79;
  localparam logic [7:0] IDX_CTRL1 = 8'h8C;
  localparam logic [7:0] IDX_AES = 8'h9C;
  localparam logic [7:0] IDX_HASH = 8'h9F;
  localparam int ADDR_W = 12;
  // Field positions
  localparam int P_CRC_STD = 11;
  localparam int P_IV_PUSH = 31;
  localparam int P_MODE_PUSH = 30;
  localparam int P_MODE = 6;
  localparam int P_CBC = 5;
  localparam int P_DECRYPT = 4;
  localparam int P_MEM_IDX = 2;
  localparam int P_KEY_ADDR = 0;
  localparam int P_RK_RESET = 31;
  localparam int P_ROUNDS = 0;
  localparam int P_THR_INIT = 24;
  localparam int P_CORE_BUSY = 15;
  localparam int P_ACT_THREAD = 12;
  localparam int P_THR_EN = 8;
  localparam int P_SLICE = 0;
  localparam int P_XFER = 16;
  localparam int P_BURST = 10;
  localparam int P_SPEED = 2;
  localparam int P_URGENT = 1;
  localparam int P_WR_AVAIL = 0;
  localparam int P_MEM_ST = 20;
  localparam int P_CACHE_ST = 18;
  localparam int P_DESC_ST = 14;
  localparam int P_AES_CH = 8;
  localparam int P_HASH_RD = 4;
  localparam int P_SAVE_INIT = 2;
  localparam int P_HASH_WR = 0;
  // Reset values
  localparam logic [7:0] SLICE_RST = 8'h01;
  localparam logic WR_AVAIL_RST = 1'b1;
  // Slice unit is 256 bytes, so the low byte of the byte counter runs to FF
  localparam logic [7:0] SLICE_LOW_END = 8'hFF;
  // Round-key storage
  localparam int RK_DEPTH = 64;
  localparam int RK_PTR_W = 6;

  // Status that the engine core presents for readback
  typedef struct packed {
    logic [3:0][7:0] descCount;
    logic [63:0] currentIv;
    logic coreBusy;
    logic [1:0] activeThreadId;
    logic [4:0] memoryStateMonitor;
    logic [1:0] tableCacheStateMonitor;
    logic [3:0] descriptorStateMonitor;
    logic [15:0] transferStateMonitor;
  } engStatus_t;

  // Cipher settings looked up for the active descriptor
  typedef struct packed {
    logic [63:0] iv;
    logic [2:0] mode;
    logic cbc;
    logic decrypt;
  } cipherCfg_t;

  // Software controls steering the engine
  typedef struct packed {
    logic crcStd;
    logic [3:0] roundCount;
    logic [3:0] threadInit;
    logic [3:0] threadEnable;
    logic [7:0] defaultSlice;
    logic [1:0] hashRdThread;
    logic [1:0] hashWrThread;
    logic hashSaveInit;
    logic [1:0] aesKeyChannel;
    logic [5:0] burstLen;
    logic memUrgent;
    logic speedUp;
    logic wrAvailEn;
  } ctrl_t;
endpackage : crypto_dma_pkg

// ### rtl/crypto_dma_thread_control.sv
// Register block and thread control of the crypto DMA engine
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module crypto_dma_thread_control (
  input wire logic sys_clk, // System clock, 250 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [crypto_dma_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire crypto_dma_pkg::engStatus_t engStatus, // Engine status for readback
  input wire logic [1:0] cipherIndex, // Cipher index of active descriptor
  input wire logic [7:0] descSlice, // Descriptor slice count, 0 uses default
  input wire logic sliceStart, // Pulse: new thread slice begins
  input wire logic byteBeat, // Pulse: one byte transferred
  input wire logic lastByteIssued, // Pulse: final byte of block sent
  input wire logic lastByteWritten, // Pulse: final byte landed in memory
  input wire logic [crypto_dma_pkg::RK_PTR_W-1:0] rkReadAddr, // Round-key read address
  output crypto_dma_pkg::cipherCfg_t cipherCfg, // IV and mode for active descriptor
  output logic [3:0] keySelect, // One-hot key0, key1, key2, IV
  output crypto_dma_pkg::ctrl_t ctrl, // Software controls
  output logic [31:0] rkData, // Round-key word at read address
  output logic [crypto_dma_pkg::RK_PTR_W-1:0] rkWritePtr, // Round-key fill level
  output logic threadSwitch, // Pulse: slice used up, move to next thread
  output logic blockDone // Pulse: block finished, engine may advance
);

  typedef struct packed {
    logic ack;
    logic slverr;
    logic [31:0] rdata;
    logic [63:0] ivStage;
    logic [2:0] mode;
    logic cbc;
    logic decrypt;
    logic [1:0] memIdx;
    logic [1:0] keyAddr;
    logic [3:0][63:0] ivMem;
    logic [3:0][4:0] modeMem;
    logic [crypto_dma_pkg::RK_PTR_W-1:0] rkPtr;
    logic [crypto_dma_pkg::RK_DEPTH-1:0][31:0] rkMem;
    logic [31:0] rkLast;
    logic [31:0] rkOut;
    crypto_dma_pkg::ctrl_t ctrl;
    crypto_dma_pkg::cipherCfg_t cfg;
    logic [3:0] keySel;
    logic [7:0] sliceLimit;
    logic [15:0] sliceBytes;
    logic threadSwitch;
    logic blockPending;
    logic blockDone;
  } state_t;

  state_t s;
  state_t next_s;
  logic rstMeta;
  logic rstSync;
  logic [7:0] idx;
  logic wrStrobe;
  logic capture;
  logic [15:0] sliceEnd;

  // Register index of a byte address; misaligned addresses never hit
  function automatic logic [7:0] regIndex(input logic [crypto_dma_pkg::ADDR_W-1:0] a);
    regIndex = a[9:2];
  endfunction : regIndex

  // True when the address names a mapped register
  function automatic logic isMapped(input logic [crypto_dma_pkg::ADDR_W-1:0] a);
    logic [7:0] i;
    i = regIndex(a);
    isMapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
      (i == crypto_dma_pkg::IDX_CRC || i == crypto_dma_pkg::IDX_COUNTS ||
       i == crypto_dma_pkg::IDX_IV_LO || i == crypto_dma_pkg::IDX_IV_HI ||
       i == crypto_dma_pkg::IDX_TRIPLE || i == crypto_dma_pkg::IDX_BLOCK ||
       i == crypto_dma_pkg::IDX_RKFIFO || i == crypto_dma_pkg::IDX_THREAD ||
       i == crypto_dma_pkg::IDX_CTRL1 || i == crypto_dma_pkg::IDX_AES ||
       i == crypto_dma_pkg::IDX_HASH);
  endfunction : isMapped

  // Reset release through two flops; only the second is used by logic
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // One wait state: data is captured first, then pready is raised
  assign idx = regIndex(paddr);
  assign capture = psel && penable && !s.ack;
  assign wrStrobe = psel && penable && s.ack && pwrite && isMapped(paddr);

  // Index of the last beat of a slice; a zero limit counts as one unit
  assign sliceEnd = (s.sliceLimit == 8'h00) ? {8'h00, crypto_dma_pkg::SLICE_LOW_END} :
    {s.sliceLimit - 8'h01, crypto_dma_pkg::SLICE_LOW_END};

  always_comb begin
    next_s = s;
    // Pulses last a single cycle
    next_s.ctrl.hashSaveInit = 1'b0;
    next_s.threadSwitch = 1'b0;
    next_s.blockDone = 1'b0;
    next_s.ack = capture;
    next_s.slverr = capture && !isMapped(paddr);

    // Read mux, sampled in the first access cycle
    if (capture) begin
      next_s.rdata = 32'h0000_0000;
      if (!pwrite && isMapped(paddr)) begin
        case (idx)
          crypto_dma_pkg::IDX_CRC: begin
            next_s.rdata[crypto_dma_pkg::P_CRC_STD] = s.ctrl.crcStd;
          end

          crypto_dma_pkg::IDX_COUNTS: begin
            // Live counts, thread 3 in the top byte
            next_s.rdata = engStatus.descCount;
          end

          crypto_dma_pkg::IDX_IV_LO: begin
            // IV in use, not the staged copy
            next_s.rdata = engStatus.currentIv[31:0];
          end
          crypto_dma_pkg::IDX_IV_HI: begin
            next_s.rdata = engStatus.currentIv[63:32];
          end
          crypto_dma_pkg::IDX_TRIPLE: begin
            // Push bits are not stored, so they read as zero
            next_s.rdata[crypto_dma_pkg::P_MODE +: 3] = s.mode;
            next_s.rdata[crypto_dma_pkg::P_CBC] = s.cbc;
            next_s.rdata[crypto_dma_pkg::P_DECRYPT] = s.decrypt;
            next_s.rdata[crypto_dma_pkg::P_MEM_IDX +: 2] = s.memIdx;
            next_s.rdata[crypto_dma_pkg::P_KEY_ADDR +: 2] = s.keyAddr;
          end
          crypto_dma_pkg::IDX_BLOCK: begin
            next_s.rdata[crypto_dma_pkg::P_ROUNDS +: 4] = s.ctrl.roundCount;
          end

          crypto_dma_pkg::IDX_RKFIFO: begin
            // Stored words stay hidden; last one echoes
            next_s.rdata = s.rkLast;
          end

          crypto_dma_pkg::IDX_THREAD: begin
            // Busy and thread id are live inputs
            next_s.rdata[crypto_dma_pkg::P_THR_INIT +: 4] = s.ctrl.threadInit;
            next_s.rdata[crypto_dma_pkg::P_CORE_BUSY] = engStatus.coreBusy;
            next_s.rdata[crypto_dma_pkg::P_ACT_THREAD +: 2] = engStatus.activeThreadId;
            next_s.rdata[crypto_dma_pkg::P_THR_EN +: 4] = s.ctrl.threadEnable;
            next_s.rdata[crypto_dma_pkg::P_SLICE +: 8] = s.ctrl.defaultSlice;
          end

          crypto_dma_pkg::IDX_CTRL1: begin
            // Reserved bits 9:3 read as zero
            next_s.rdata[crypto_dma_pkg::P_XFER +: 16] = engStatus.transferStateMonitor;
            next_s.rdata[crypto_dma_pkg::P_BURST +: 6] = s.ctrl.burstLen;
            next_s.rdata[crypto_dma_pkg::P_SPEED] = s.ctrl.speedUp;
            next_s.rdata[crypto_dma_pkg::P_URGENT] = s.ctrl.memUrgent;
            next_s.rdata[crypto_dma_pkg::P_WR_AVAIL] = s.ctrl.wrAvailEn;
          end

          crypto_dma_pkg::IDX_AES: begin
            // Monitors pass through, never stored
            next_s.rdata[crypto_dma_pkg::P_MEM_ST +: 5] = engStatus.memoryStateMonitor;
            next_s.rdata[crypto_dma_pkg::P_CACHE_ST +: 2] =
              engStatus.tableCacheStateMonitor;
            next_s.rdata[crypto_dma_pkg::P_DESC_ST +: 4] =
              engStatus.descriptorStateMonitor;
            next_s.rdata[crypto_dma_pkg::P_AES_CH +: 2] = s.ctrl.aesKeyChannel;
          end

          crypto_dma_pkg::IDX_HASH: begin
            // Save-init reads as zero
            next_s.rdata[crypto_dma_pkg::P_HASH_RD +: 2] = s.ctrl.hashRdThread;
            next_s.rdata[crypto_dma_pkg::P_HASH_WR +: 2] = s.ctrl.hashWrThread;
          end
          default: begin
            next_s.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Writes take effect at the edge where pready is high
    if (wrStrobe) begin
      case (idx)
        crypto_dma_pkg::IDX_CRC: begin
          // Other bits of this word are reserved
          next_s.ctrl.crcStd = pwdata[crypto_dma_pkg::P_CRC_STD];
        end
        crypto_dma_pkg::IDX_IV_LO: begin
          // Staging only; a push moves it
          next_s.ivStage[31:0] = pwdata;
        end
        crypto_dma_pkg::IDX_IV_HI: begin
          next_s.ivStage[63:32] = pwdata;
        end
        crypto_dma_pkg::IDX_TRIPLE: begin
          next_s.mode = pwdata[crypto_dma_pkg::P_MODE +: 3];
          next_s.cbc = pwdata[crypto_dma_pkg::P_CBC];
          next_s.decrypt = pwdata[crypto_dma_pkg::P_DECRYPT];
          next_s.memIdx = pwdata[crypto_dma_pkg::P_MEM_IDX +: 2];
          next_s.keyAddr = pwdata[crypto_dma_pkg::P_KEY_ADDR +: 2];
          // Push uses the index written with the same word, and the old shadow
          if (pwdata[crypto_dma_pkg::P_IV_PUSH]) begin
            next_s.ivMem[pwdata[crypto_dma_pkg::P_MEM_IDX +: 2]] = s.ivStage;
          end
          if (pwdata[crypto_dma_pkg::P_MODE_PUSH]) begin
            next_s.modeMem[pwdata[crypto_dma_pkg::P_MEM_IDX +: 2]] =
              {s.mode, s.cbc, s.decrypt};
          end
        end
        crypto_dma_pkg::IDX_BLOCK: begin
          // Pointer clear is an action, not state
          next_s.ctrl.roundCount = pwdata[crypto_dma_pkg::P_ROUNDS +: 4];
          if (pwdata[crypto_dma_pkg::P_RK_RESET]) begin
            next_s.rkPtr = '0;
          end
        end
        crypto_dma_pkg::IDX_RKFIFO: begin
          // Pointer wraps past the last slot; software owns the fill level
          next_s.rkMem[s.rkPtr] = pwdata;
          next_s.rkPtr = s.rkPtr + 1'b1;
          next_s.rkLast = pwdata;
        end
        crypto_dma_pkg::IDX_THREAD: begin
          // Busy and thread id ignore writes
          next_s.ctrl.threadInit = pwdata[crypto_dma_pkg::P_THR_INIT +: 4];
          next_s.ctrl.threadEnable = pwdata[crypto_dma_pkg::P_THR_EN +: 4];
          next_s.ctrl.defaultSlice = pwdata[crypto_dma_pkg::P_SLICE +: 8];
        end
        crypto_dma_pkg::IDX_CTRL1: begin
          // Monitor half is read-only
          next_s.ctrl.burstLen = pwdata[crypto_dma_pkg::P_BURST +: 6];
          next_s.ctrl.speedUp = pwdata[crypto_dma_pkg::P_SPEED];
          next_s.ctrl.memUrgent = pwdata[crypto_dma_pkg::P_URGENT];
          next_s.ctrl.wrAvailEn = pwdata[crypto_dma_pkg::P_WR_AVAIL];
        end
        crypto_dma_pkg::IDX_AES: begin
          next_s.ctrl.aesKeyChannel = pwdata[crypto_dma_pkg::P_AES_CH +: 2];
        end
        crypto_dma_pkg::IDX_HASH: begin
          next_s.ctrl.hashRdThread = pwdata[crypto_dma_pkg::P_HASH_RD +: 2];
          next_s.ctrl.hashWrThread = pwdata[crypto_dma_pkg::P_HASH_WR +: 2];
          next_s.ctrl.hashSaveInit = pwdata[crypto_dma_pkg::P_SAVE_INIT];
        end
        default: begin
          // Counts register: writes are dropped
          next_s.rdata = s.rdata;
        end
      endcase
    end

    // Descriptor lookup uses the pushed copies, never the shadow fields
    next_s.cfg.iv = s.ivMem[cipherIndex];
    {next_s.cfg.mode, next_s.cfg.cbc, next_s.cfg.decrypt} = s.modeMem[cipherIndex];
    next_s.keySel = 4'h1 << s.keyAddr;
    // Round-key read has one cycle of latency
    next_s.rkOut = s.rkMem[rkReadAddr];

    // Slice accounting: limit is latched when the slice begins
    if (sliceStart) begin
      next_s.sliceLimit = (descSlice == 8'h00) ? s.ctrl.defaultSlice : descSlice;
      next_s.sliceBytes = 16'h0000;
    // A beat in the start cycle is dropped
    end else if (byteBeat) begin
      if (s.sliceBytes == sliceEnd) begin
        next_s.threadSwitch = 1'b1;
        next_s.sliceBytes = 16'h0000;
      end else begin
        next_s.sliceBytes = s.sliceBytes + 16'h0001;
      end
    end

    // Block completion; with the wait enabled it needs the memory's own ack
    // A landing ack with nothing pending is dropped
    if (!s.ctrl.wrAvailEn) begin
      next_s.blockDone = lastByteIssued;
      next_s.blockPending = 1'b0;
    end else if (lastByteWritten && (s.blockPending || lastByteIssued)) begin
      next_s.blockDone = 1'b1;
      next_s.blockPending = 1'b0;
    end else if (lastByteIssued) begin
      next_s.blockPending = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      // Clear all, then fields with nonzero reset
      s <= '0;
      s.ctrl.defaultSlice <= crypto_dma_pkg::SLICE_RST;
      s.ctrl.wrAvailEn <= crypto_dma_pkg::WR_AVAIL_RST;
      s.keySel <= 4'h1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign prdata = s.rdata;
  assign pready = s.ack;
  // Error only stands together with ready
  assign pslverr = s.ack && s.slverr;
  assign cipherCfg = s.cfg;
  assign keySelect = s.keySel;
  assign ctrl = s.ctrl;
  assign rkData = s.rkOut;
  assign rkWritePtr = s.rkPtr;
  assign threadSwitch = s.threadSwitch;
  assign blockDone = s.blockDone;

endmodule : crypto_dma_thread_control

// ### sim/crypto_dma_thread_control_chk.sv
// Port-level checker for the crypto DMA control block
`timescale 1ns/1ps
module crypto_dma_thread_control_chk (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [crypto_dma_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire crypto_dma_pkg::engStatus_t engStatus, // Engine status
  input wire logic [3:0] keySelect, // Key select
  input wire crypto_dma_pkg::ctrl_t ctrl, // Software controls
  input wire logic [crypto_dma_pkg::RK_PTR_W-1:0] rkWritePtr, // Round-key pointer
  input wire logic byteBeat, // Byte pulse
  input wire logic lastByteIssued, // Final byte sent
  input wire logic lastByteWritten, // Final byte landed
  input wire logic threadSwitch, // Slice used up
  input wire logic blockDone // Block finished
);
  // Completed mapped transfers; an erroring one must leave no trace
  wire logic wrAcc = psel && penable && pready && pwrite && !pslverr;
  wire logic rdAcc = psel && penable && pready && !pwrite && !pslverr;
  wire logic [7:0] idx = paddr[9:2];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_crc_select: assert property (wrAcc && idx == crypto_dma_pkg::IDX_CRC
    |=> ctrl.crcStd == $past(pwdata[11])) else $error("crc select not taken");
  chk_count_read: assert property (rdAcc && idx == crypto_dma_pkg::IDX_COUNTS
    |-> prdata == $past(engStatus.descCount)) else $error("count read wrong");
  chk_iv_read: assert property (rdAcc && idx == crypto_dma_pkg::IDX_IV_LO
    |-> prdata == $past(engStatus.currentIv[31:0])) else $error("iv read wrong");
  chk_push_zero: assert property (rdAcc && idx == crypto_dma_pkg::IDX_TRIPLE
    |-> prdata[31:30] == 2'b00) else $error("push bits read back");
  chk_rk_clear: assert property (wrAcc && idx == crypto_dma_pkg::IDX_BLOCK && pwdata[31]
    |=> rkWritePtr == 6'h00) else $error("round-key pointer not cleared");
  chk_rk_step: assert property (wrAcc && idx == crypto_dma_pkg::IDX_RKFIFO
    |=> rkWritePtr == $past(rkWritePtr) + 6'h01) else $error("round-key pointer not advanced");
  chk_save_pulse: assert property (wrAcc && idx == crypto_dma_pkg::IDX_HASH && pwdata[2]
    |=> ctrl.hashSaveInit ##1 !ctrl.hashSaveInit) else $error("save-init not one pulse");
  chk_key_onehot: assert property ($onehot(keySelect)) else $error("key select not one-hot");
  chk_switch_cause: assert property (threadSwitch |-> $past(byteBeat))
    else $error("thread switch without a byte");
  chk_done_direct: assert property (!ctrl.wrAvailEn && lastByteIssued |=> blockDone)
    else $error("block done late");
  chk_done_wait: assert property (ctrl.wrAvailEn && lastByteIssued && !lastByteWritten
    |=> !blockDone) else $error("block done before data landed");
endmodule : crypto_dma_thread_control_chk

bind crypto_dma_thread_control crypto_dma_thread_control_chk i_crypto_dma_thread_control_chk (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .engStatus(engStatus), .keySelect(keySelect), .ctrl(ctrl), .rkWritePtr(rkWritePtr),
  .byteBeat(byteBeat), .lastByteIssued(lastByteIssued), .lastByteWritten(lastByteWritten),
  .threadSwitch(threadSwitch), .blockDone(blockDone));

// ### sim/engine_side_model.sv
// Engine core and memory side model feeding the crypto DMA control block
`timescale 1ns/1ps
module engine_side_model (
  input wire logic sys_clk, // System clock
  output crypto_dma_pkg::engStatus_t engStatus, // Status shown to software
  output logic [1:0] cipherIndex, // Descriptor cipher index
  output logic [7:0] descSlice, // Descriptor slice count
  output logic sliceStart, // New slice pulse
  output logic byteBeat, // Byte moved pulse
  output logic lastByteIssued, // Final byte sent pulse
  output logic lastByteWritten, // Final byte landed pulse
  output logic [5:0] rkReadAddr // Round-key read address
);
  // Distinct bytes per field so a swapped or shifted field shows up
  initial begin
    engStatus = {32'h44332211, 64'h89ABCDEF01234567, 1'b1, 2'h2, 5'h11, 2'h3, 4'hC, 16'h0800};
    {cipherIndex, descSlice, sliceStart, byteBeat} = 12'h000;
    {lastByteIssued, lastByteWritten, rkReadAddr} = 8'h00;
  end
  // Descriptor cipher index, held while the engine looks it up
  task select(input logic [1:0] k);
    @(posedge sys_clk);
    cipherIndex <= k;
    repeat (2) @(posedge sys_clk);
  endtask : select
  task read_key(input logic [5:0] a);
    @(posedge sys_clk);
    rkReadAddr <= a;
    repeat (2) @(posedge sys_clk);
  endtask : read_key
  // Slice count is only good at the start pulse; afterwards it is scrambled
  task run(input logic start, input logic [7:0] s, input int n);
    @(posedge sys_clk);
    sliceStart <= start;
    descSlice <= s;
    repeat (n) begin
      @(posedge sys_clk);
      sliceStart <= 1'b0;
      descSlice <= ~s;
      byteBeat <= 1'b1;
    end
    @(posedge sys_clk);
    sliceStart <= 1'b0;
    byteBeat <= 1'b0;
  endtask : run
  // Engine status moves on; readback must follow it
  task set_status(input crypto_dma_pkg::engStatus_t v);
    @(posedge sys_clk);
    engStatus <= v;
  endtask : set_status
  // Final byte sent, or final byte landed in memory, as one pulse
  task last_byte(input logic landed);
    @(posedge sys_clk);
    lastByteIssued <= !landed;
    lastByteWritten <= landed;
    @(posedge sys_clk);
    lastByteIssued <= 1'b0;
    lastByteWritten <= 1'b0;
  endtask : last_byte
endmodule : engine_side_model

// ### sim/testbench.sv
// Self-checking bench for the crypto DMA control block
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rkData, rd;
  logic pready, pslverr, err, sliceStart, byteBeat, lastByteIssued, lastByteWritten;
  logic threadSwitch, blockDone;
  logic [1:0] cipherIndex;
  logic [7:0] descSlice;
  logic [5:0] rkReadAddr, rkWritePtr;
  logic [3:0] keySelect;
  crypto_dma_pkg::engStatus_t engStatus;
  crypto_dma_pkg::cipherCfg_t cipherCfg;
  crypto_dma_pkg::ctrl_t ctrl;
  int n_fail = 0, compares = 0, switches = 0, dones = 0;

  always #2 sys_clk = ~sys_clk;
  // Pulse counters, so short outputs are never missed between checks
  always @(posedge sys_clk) begin
    if (threadSwitch === 1'b1) switches++;
    if (blockDone === 1'b1) dones++;
  end

  crypto_dma_thread_control i_crypto_dma_thread_control (.sys_clk(sys_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .engStatus(engStatus),
    .cipherIndex(cipherIndex), .descSlice(descSlice), .sliceStart(sliceStart),
    .byteBeat(byteBeat), .lastByteIssued(lastByteIssued), .lastByteWritten(lastByteWritten),
    .rkReadAddr(rkReadAddr), .cipherCfg(cipherCfg), .keySelect(keySelect), .ctrl(ctrl),
    .rkData(rkData), .rkWritePtr(rkWritePtr), .threadSwitch(threadSwitch),
    .blockDone(blockDone));
  engine_side_model i_engine_side_model (.sys_clk(sys_clk), .engStatus(engStatus),
    .cipherIndex(cipherIndex), .descSlice(descSlice), .sliceStart(sliceStart),
    .byteBeat(byteBeat), .lastByteIssued(lastByteIssued), .lastByteWritten(lastByteWritten),
    .rkReadAddr(rkReadAddr));

  task finish_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task check(input logic [68:0] got, input logic [68:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] i, input logic [31:0] d);
    apb({2'b00, i, 2'b00}, 1'b1, d);
  endtask : wr
  task rdchk(input logic [7:0] i, input logic [31:0] e);
    apb({2'b00, i, 2'b00}, 1'b0, 32'h0);
    check(rd, e);
  endtask : rdchk

  task t_status;
    rdchk(crypto_dma_pkg::IDX_THREAD, 32'h0000A001);
    rdchk(crypto_dma_pkg::IDX_CTRL1, 32'h08000001);
    wr(crypto_dma_pkg::IDX_COUNTS, 32'hFFFFFFFF);
    rdchk(crypto_dma_pkg::IDX_COUNTS, 32'h44332211);
    rdchk(crypto_dma_pkg::IDX_IV_HI, 32'h89ABCDEF);
    rdchk(crypto_dma_pkg::IDX_AES, 32'h011F0000);
    apb(12'h1C6, 1'b1, 32'h0);
    check(err, 1'b1);
    wr(crypto_dma_pkg::IDX_CRC, 32'h00000800);
    tick(1);
    check(ctrl.crcStd, 1'b1);
    wr(crypto_dma_pkg::IDX_CRC, 32'h0);
    tick(1);
    check(ctrl.crcStd, 1'b0);
  endtask : t_status
  // Two slots filled; a later slot must not disturb an earlier one
  task t_cipher;
    wr(crypto_dma_pkg::IDX_IV_LO, 32'hCAFE0001);
    wr(crypto_dma_pkg::IDX_IV_HI, 32'h5A5A0002);
    wr(crypto_dma_pkg::IDX_TRIPLE, 32'h00000178);
    wr(crypto_dma_pkg::IDX_TRIPLE, 32'hC0000178);
    wr(crypto_dma_pkg::IDX_IV_LO, 32'h11110003);
    wr(crypto_dma_pkg::IDX_IV_HI, 32'h22220004);
    wr(crypto_dma_pkg::IDX_TRIPLE, 32'h00000084);
    wr(crypto_dma_pkg::IDX_TRIPLE, 32'hC0000084);
    rdchk(crypto_dma_pkg::IDX_TRIPLE, 32'h00000084);
    i_engine_side_model.select(2'h2);
    check(cipherCfg, {64'h5A5A0002CAFE0001, 3'h5, 2'b11});
    i_engine_side_model.select(2'h1);
    check(cipherCfg, {64'h2222000411110003, 3'h2, 2'b00});
    for (int k = 0; k < 4; k++) begin
      wr(crypto_dma_pkg::IDX_TRIPLE, 32'h00000084 | k);
      tick(2);
      check(keySelect, 4'h1 << k);
    end
  endtask : t_cipher
  task t_round_keys;
    wr(crypto_dma_pkg::IDX_RKFIFO, 32'hDEAD0000);
    wr(crypto_dma_pkg::IDX_BLOCK, 32'h8000000E);
    tick(1);
    check(rkWritePtr, 6'h00);
    check(ctrl.roundCount, 4'hE);
    rdchk(crypto_dma_pkg::IDX_BLOCK, 32'h0000000E);
    for (int k = 0; k < 3; k++) wr(crypto_dma_pkg::IDX_RKFIFO, 32'hA0000000 + k);
    tick(1);
    check(rkWritePtr, 6'h03);
    i_engine_side_model.read_key(6'h01);
    check(rkData, 32'hA0000001);
  endtask : t_round_keys
  // Default slice of two units, then a descriptor slice of one
  task t_threads;
    wr(crypto_dma_pkg::IDX_THREAD, 32'h05000A02);
    rdchk(crypto_dma_pkg::IDX_THREAD, 32'h0500AA02);
    check(ctrl.threadEnable, 4'hA);
    check(ctrl.threadInit, 4'h5);
    i_engine_side_model.run(1'b1, 8'h00, 511);
    tick(3);
    check(switches, 0);
    i_engine_side_model.run(1'b0, 8'h00, 1);
    tick(3);
    check(switches, 1);
    i_engine_side_model.run(1'b1, 8'h01, 256);
    tick(3);
    check(switches, 2);
  endtask : t_threads
  task t_memory;
    wr(crypto_dma_pkg::IDX_CTRL1, 32'h0000A806);
    tick(1);
    check({ctrl.burstLen, ctrl.speedUp, ctrl.memUrgent}, 8'hAB);
    i_engine_side_model.last_byte(1'b0);
    tick(3);
    check(dones, 1);
    wr(crypto_dma_pkg::IDX_CTRL1, 32'h00000001);
    i_engine_side_model.last_byte(1'b0);
    tick(4);
    check(dones, 1);
    i_engine_side_model.last_byte(1'b1);
    tick(3);
    check(dones, 2);
  endtask : t_memory
  task t_hash_aes;
    wr(crypto_dma_pkg::IDX_HASH, 32'h00000036);
    tick(1);
    check({ctrl.hashSaveInit, ctrl.hashRdThread, ctrl.hashWrThread}, 5'h1E);
    rdchk(crypto_dma_pkg::IDX_HASH, 32'h00000032);
    wr(crypto_dma_pkg::IDX_AES, 32'h00000100);
    rdchk(crypto_dma_pkg::IDX_AES, 32'h011F0100);
    i_engine_side_model.set_status({32'h0102A0B0, 64'h13579BDF2468ACE0, 1'b0, 2'h1,
      5'h0A, 2'h1, 4'h5, 16'h0010});
    rdchk(crypto_dma_pkg::IDX_COUNTS, 32'h0102A0B0);
    rdchk(crypto_dma_pkg::IDX_IV_LO, 32'h2468ACE0);
    rdchk(crypto_dma_pkg::IDX_THREAD, 32'h05001A02);
    rdchk(crypto_dma_pkg::IDX_AES, 32'h00A54100);
  endtask : t_hash_aes

  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    tick(4);
    check(ctrl.defaultSlice, 8'h01);
    t_status();
    t_cipher();
    t_round_keys();
    t_threads();
    t_memory();
    t_hash_aes();
    finish_test();
  end
  // Tests take about a thousand cycles; this cuts a hang short
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
endmodule : testbench
